// [hw/cidt_pkg.sv]
//////////////////////////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////////////////////////
package cidt_pkg;

  localparam int WORD_W   = 24;
  localparam int OPC_W    = 8;
  localparam int OPC_HI   = 23;
  localparam int OPC_LO   = 16;
  localparam int CAT_HI   = 7;
  localparam int CAT_LO   = 6;
  localparam int FORM_BIT = 5;
  localparam int VAR_BIT  = 0;
  localparam int DMODE_HI = 1;
  localparam int DMODE_LO = 0;
  localparam int BYTE_BIT = 15;
  localparam int BASE_HI  = 14;
  localparam int BASE_LO  = 11;
  localparam int DEST_HI  = 10;
  localparam int DEST_LO  = 7;
  localparam int SMODE_HI = 6;
  localparam int SMODE_LO = 4;
  localparam int SRC_HI   = 3;
  localparam int SRC_LO   = 0;
  localparam int WZ_BIT   = 14;
  localparam int FILE_HI  = 13;
  localparam int FILE_LO  = 0;
  localparam int BPOS_HI  = 15;
  localparam int BPOS_LO  = 12;
  localparam int BIND_BIT = 11;
  localparam int BFILE_HI = 10;
  localparam int LMOV_HI  = 15;
  localparam int LMOV_LO  = 4;
  localparam int LFK_HI   = 15;
  localparam int LFK_LO   = 8;
  localparam int LFA_HI   = 7;
  localparam int LAR_HI   = 10;
  localparam int LAR_LO   = 4;
  localparam int PADR_HI  = 15;
  localparam int PADR_LO  = 0;
  localparam int PEXT_HI  = 6;
  localparam int TMOD_HI  = 15;
  localparam int TMOD_LO  = 14;

  typedef logic [OPC_W-1:0]  cidt_opcode_type;
  typedef logic [WORD_W-1:0] cidt_word_type;
  typedef logic [13:0]       cidt_faddr_type;
  typedef logic [15:0]       cidt_literal_type;
  typedef logic [1:0]        cidt_cycles_type;

  typedef enum logic [1:0] {
    CAT_CONTROL  = 2'b00,
    CAT_WORDBYTE = 2'b01,
    CAT_BIT      = 2'b10,
    CAT_LITERAL  = 2'b11
  } cidt_category_type;

  typedef enum logic [2:0] {
    ST_READY  = 3'b000,
    ST_SECOND = 3'b001,
    ST_STALL  = 3'b010,
    ST_SKIP   = 3'b011,
    ST_SKIP2  = 3'b100
  } cidt_phase_type;

  localparam cidt_opcode_type OP_NOP        = 8'h00;
  localparam cidt_opcode_type OP_BRA_ALWAYS = 8'h01;
  localparam cidt_opcode_type OP_BRA_COND   = 8'h02;
  localparam cidt_opcode_type OP_CALL_IND   = 8'h03;
  localparam cidt_opcode_type OP_GOTO_IND   = 8'h04;
  localparam cidt_opcode_type OP_TBL_READ   = 8'h05;
  localparam cidt_opcode_type OP_TBL_WRITE  = 8'h06;
  localparam cidt_opcode_type OP_RETURN     = 8'h07;
  localparam cidt_opcode_type OP_RET_INT    = 8'h08;
  localparam cidt_opcode_type OP_GOTO_DW    = 8'h09;
  localparam cidt_opcode_type OP_CALL_DW    = 8'h0a;
  localparam cidt_opcode_type OP_MOVE_DBL   = 8'h7c;
  localparam cidt_opcode_type OP_CMP_SKIP   = 8'h7e;
  localparam cidt_opcode_type OP_BIT_SKIP   = 8'hbe;
  localparam cidt_opcode_type OP_MOVLIT_DW  = 8'hc2;

  localparam cidt_cycles_type CYC_ZERO   = 2'h0;
  localparam cidt_cycles_type CYC_ONE    = 2'h1;
  localparam cidt_cycles_type CYC_TWO    = 2'h2;

  typedef struct packed {
    logic              valid;
    cidt_word_type     word;
  } cidt_fetch_type;

  typedef struct packed {
    logic              byteMode;
    logic [3:0]        baseReg;
    logic [3:0]        sourceReg;
    logic [2:0]        sourceMode;
    logic [3:0]        destReg;
    logic [1:0]        destMode;
    logic              useFile;
    cidt_faddr_type    fileAddr;
    logic              toWorkingRegZero;
    cidt_literal_type  literal;
    logic [3:0]        bitPos;
    logic              bitIndirect;
    logic [22:0]       progAddr;
    logic [1:0]        tableMode;
  } cidt_operand_type;

  typedef struct packed {
    logic              execute;
    logic              squash;
    cidt_category_type category;
    cidt_opcode_type   opcode;
    cidt_operand_type  ops;
    logic              doubleWord;
    cidt_cycles_type   cycles;
  } cidt_decode_type;

  typedef struct packed {
    cidt_phase_type    phase;
    cidt_cycles_type   count;
    cidt_word_type     firstWord;
    cidt_decode_type   out;
  } cidt_state_type;

  function automatic logic isDoubleWord(input cidt_opcode_type op);
    return (op == OP_GOTO_DW) || (op == OP_CALL_DW) || (op == OP_MOVLIT_DW);
  endfunction : isDoubleWord

  function automatic logic isSkip(input cidt_opcode_type op);
    return (op == OP_CMP_SKIP) || (op == OP_BIT_SKIP);
  endfunction : isSkip

  function automatic cidt_cycles_type extraCycles(input cidt_opcode_type op, input logic cond);
    unique case (op)
      OP_BRA_ALWAYS, OP_CALL_IND, OP_GOTO_IND,
      OP_TBL_READ, OP_TBL_WRITE, OP_MOVE_DBL: return CYC_ONE;
      OP_RETURN, OP_RET_INT:                  return CYC_TWO;
      OP_BRA_COND:                            return cond ? CYC_ONE : CYC_ZERO;
      default:                                return CYC_ZERO;
    endcase
  endfunction : extraCycles

endpackage : cidt_pkg

// [hw/cidt_operand_extract.sv]
`timescale 1ns/100ps
`default_nettype none
module cidt_operand_extract (
  input  wire cidt_pkg::cidt_word_type    firstWord,
  input  wire cidt_pkg::cidt_word_type    secondWord,
  output var  cidt_pkg::cidt_operand_type ops
);

  cidt_pkg::cidt_opcode_type   op;
  cidt_pkg::cidt_category_type cat;

  assign op  = firstWord[cidt_pkg::OPC_HI:cidt_pkg::OPC_LO];
  assign cat = cidt_pkg::cidt_category_type'(op[cidt_pkg::CAT_HI:cidt_pkg::CAT_LO]);

  always_comb begin
    ops          = '0;
    ops.byteMode = firstWord[cidt_pkg::BYTE_BIT];
    unique case (cat)
      cidt_pkg::CAT_WORDBYTE: begin
        if (op[cidt_pkg::FORM_BIT]) begin
          ops.useFile          = 1'b1;
          ops.fileAddr         = firstWord[cidt_pkg::FILE_HI:cidt_pkg::FILE_LO];
          ops.toWorkingRegZero = firstWord[cidt_pkg::WZ_BIT];
        end else begin
          ops.baseReg    = firstWord[cidt_pkg::BASE_HI:cidt_pkg::BASE_LO];
          ops.sourceReg  = firstWord[cidt_pkg::SRC_HI:cidt_pkg::SRC_LO];
          ops.sourceMode = firstWord[cidt_pkg::SMODE_HI:cidt_pkg::SMODE_LO];
          ops.destReg    = firstWord[cidt_pkg::DEST_HI:cidt_pkg::DEST_LO];
          ops.destMode   = op[cidt_pkg::DMODE_HI:cidt_pkg::DMODE_LO];
        end
      end
      cidt_pkg::CAT_BIT: begin
        ops.bitPos = firstWord[cidt_pkg::BPOS_HI:cidt_pkg::BPOS_LO];
        if (op[cidt_pkg::VAR_BIT]) begin
          ops.useFile  = 1'b1;
          ops.fileAddr = cidt_pkg::cidt_faddr_type'(firstWord[cidt_pkg::BFILE_HI:cidt_pkg::FILE_LO]);
        end else begin
          ops.bitIndirect = firstWord[cidt_pkg::BIND_BIT];
          ops.baseReg     = firstWord[cidt_pkg::DEST_HI:cidt_pkg::DEST_LO];
          ops.sourceReg   = firstWord[cidt_pkg::SRC_HI:cidt_pkg::SRC_LO];
          ops.sourceMode  = firstWord[cidt_pkg::SMODE_HI:cidt_pkg::SMODE_LO];
        end
      end
      cidt_pkg::CAT_LITERAL: begin
        if (op == cidt_pkg::OP_MOVLIT_DW) begin
          ops.useFile  = 1'b1;
          ops.fileAddr = firstWord[cidt_pkg::FILE_HI:cidt_pkg::FILE_LO];
          ops.literal  = secondWord[cidt_pkg::PADR_HI:cidt_pkg::PADR_LO];
        end else if (op[cidt_pkg::FORM_BIT]) begin
          ops.baseReg = firstWord[cidt_pkg::BASE_HI:cidt_pkg::BASE_LO];
          ops.literal = cidt_pkg::cidt_literal_type'(firstWord[cidt_pkg::LAR_HI:cidt_pkg::LAR_LO]);
          ops.destReg = op[cidt_pkg::VAR_BIT] ? firstWord[cidt_pkg::SRC_HI:cidt_pkg::SRC_LO]
                                              : firstWord[cidt_pkg::BASE_HI:cidt_pkg::BASE_LO];
        end else if (op[cidt_pkg::VAR_BIT]) begin
          ops.useFile  = 1'b1;
          ops.literal  = cidt_pkg::cidt_literal_type'(firstWord[cidt_pkg::LFK_HI:cidt_pkg::LFK_LO]);
          ops.fileAddr = cidt_pkg::cidt_faddr_type'(firstWord[cidt_pkg::LFA_HI:cidt_pkg::FILE_LO]);
        end else begin
          ops.literal = cidt_pkg::cidt_literal_type'(firstWord[cidt_pkg::LMOV_HI:cidt_pkg::LMOV_LO]);
          ops.baseReg = firstWord[cidt_pkg::SRC_HI:cidt_pkg::SRC_LO];
        end
      end
      cidt_pkg::CAT_CONTROL: begin
        ops.progAddr  = {secondWord[cidt_pkg::PEXT_HI:cidt_pkg::FILE_LO],
                         firstWord[cidt_pkg::PADR_HI:cidt_pkg::PADR_LO]};
        ops.tableMode = firstWord[cidt_pkg::TMOD_HI:cidt_pkg::TMOD_LO];
        ops.sourceReg = firstWord[cidt_pkg::SRC_HI:cidt_pkg::SRC_LO];
      end
    endcase
  end

endmodule : cidt_operand_extract
`default_nettype wire

// [hw/cidt_decoder.sv]
`timescale 1ns/100ps
`default_nettype none
module cidt_decoder (
  input  wire logic                      clock,
  input  wire logic                      nrst,
  input  wire cidt_pkg::cidt_fetch_type  fetch,
  input  wire logic                      testTrue,
  output logic                           fetchReady,
  output var  cidt_pkg::cidt_decode_type decoded
);

  //////////////////////////////////////////////////////////////////////////////////////////////
  // state and decode inputs

  cidt_pkg::cidt_state_type   s;
  cidt_pkg::cidt_state_type   next_s;
  cidt_pkg::cidt_operand_type ops;
  cidt_pkg::cidt_word_type    exFirst;
  cidt_pkg::cidt_word_type    exSecond;
  cidt_pkg::cidt_opcode_type  opc;
  cidt_pkg::cidt_opcode_type  heldOpc;
  cidt_pkg::cidt_cycles_type  extra;
  logic                       take;

  assign fetchReady = (s.phase != cidt_pkg::ST_STALL);
  assign take       = fetch.valid && fetchReady;
  assign opc        = fetch.word[cidt_pkg::OPC_HI:cidt_pkg::OPC_LO];
  assign heldOpc    = s.firstWord[cidt_pkg::OPC_HI:cidt_pkg::OPC_LO];
  assign extra      = cidt_pkg::extraCycles(opc, testTrue);
  assign decoded    = s.out;

  // second word only joins the operands while finishing a double-word form
  assign exFirst  = (s.phase == cidt_pkg::ST_SECOND) ? s.firstWord : fetch.word;
  assign exSecond = (s.phase == cidt_pkg::ST_SECOND) ? fetch.word : '0;

  cidt_operand_extract u_extract (
    .firstWord  (exFirst),
    .secondWord (exSecond),
    .ops        (ops)
  );

  //////////////////////////////////////////////////////////////////////////////////////////////
  // sequencing

  always_comb begin
    next_s             = s;
    next_s.out.execute = 1'b0;
    next_s.out.squash  = 1'b0;
    unique case (s.phase)
      cidt_pkg::ST_READY: begin
        if (take) begin
          if (cidt_pkg::isDoubleWord(opc)) begin
            next_s.firstWord = fetch.word;
            next_s.phase     = cidt_pkg::ST_SECOND;
          end else begin
            next_s.out.execute    = 1'b1;
            next_s.out.category   = cidt_pkg::cidt_category_type'(
                                      opc[cidt_pkg::CAT_HI:cidt_pkg::CAT_LO]);
            next_s.out.opcode     = opc;
            next_s.out.ops        = ops;
            next_s.out.doubleWord = 1'b0;
            next_s.out.cycles     = cidt_pkg::cidt_cycles_type'(cidt_pkg::CYC_ONE + extra);
            if (cidt_pkg::isSkip(opc) && testTrue) begin
              next_s.phase = cidt_pkg::ST_SKIP;
            end else if (extra != cidt_pkg::CYC_ZERO) begin
              next_s.count = extra;
              next_s.phase = cidt_pkg::ST_STALL;
            end
          end
        end
      end
      cidt_pkg::ST_SECOND: begin
        if (take) begin
          next_s.out.execute    = 1'b1;
          next_s.out.category   = cidt_pkg::cidt_category_type'(
                                    heldOpc[cidt_pkg::CAT_HI:cidt_pkg::CAT_LO]);
          next_s.out.opcode     = heldOpc;
          next_s.out.ops        = ops;
          next_s.out.doubleWord = 1'b1;
          next_s.out.cycles     = cidt_pkg::CYC_TWO;
          next_s.phase          = cidt_pkg::ST_READY;
        end
      end
      cidt_pkg::ST_STALL: begin
        next_s.out.squash = 1'b1;
        next_s.count      = cidt_pkg::cidt_cycles_type'(s.count - cidt_pkg::CYC_ONE);
        if (s.count == cidt_pkg::CYC_ONE) begin
          next_s.phase = cidt_pkg::ST_READY;
        end
      end
      cidt_pkg::ST_SKIP: begin
        if (take) begin
          next_s.out.squash = 1'b1;
          next_s.phase      = cidt_pkg::isDoubleWord(opc) ? cidt_pkg::ST_SKIP2
                                                          : cidt_pkg::ST_READY;
        end
      end
      cidt_pkg::ST_SKIP2: begin
        if (take) begin
          next_s.out.squash = 1'b1;
          next_s.phase      = cidt_pkg::ST_READY;
        end
      end
      default: begin
        next_s.phase = cidt_pkg::ST_READY;
      end
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clock);
  endclocking

  default disable iff (!nrst);

  logic readyTake;
  assign readyTake = take && (s.phase == cidt_pkg::ST_READY);

  cidt_pkg::cidt_category_type opcCat;
  logic [3:0]                  wBase;
  logic [3:0]                  wSrc;
  logic [3:0]                  wDest;
  assign opcCat = cidt_pkg::cidt_category_type'(opc[cidt_pkg::CAT_HI:cidt_pkg::CAT_LO]);
  assign wBase  = fetch.word[cidt_pkg::BASE_HI:cidt_pkg::BASE_LO];
  assign wSrc   = fetch.word[cidt_pkg::SRC_HI:cidt_pkg::SRC_LO];
  assign wDest  = fetch.word[cidt_pkg::DEST_HI:cidt_pkg::DEST_LO];

  chk_opcode_field: assert property (
    readyTake && !cidt_pkg::isDoubleWord(opc)
      |=> decoded.execute && (decoded.opcode == $past(opc)) && !decoded.doubleWord)
    else $error("opcode not carried from fetched word");

  chk_category_map: assert property (
    decoded.execute
      |-> decoded.category == cidt_pkg::cidt_category_type'(
            decoded.opcode[cidt_pkg::CAT_HI:cidt_pkg::CAT_LO]))
    else $error("category does not follow opcode");

  chk_lone_second: assert property (
    readyTake && (opc == cidt_pkg::OP_NOP)
      |=> decoded.execute && (decoded.opcode == cidt_pkg::OP_NOP) && fetchReady
          && (decoded.cycles == cidt_pkg::CYC_ONE))
    else $error("lone second word not a one-cycle nop");

  chk_lit_dest: assert property (
    decoded.execute && (decoded.category == cidt_pkg::CAT_LITERAL)
      && decoded.opcode[cidt_pkg::FORM_BIT] && !decoded.opcode[cidt_pkg::VAR_BIT]
      |-> decoded.ops.destReg == decoded.ops.baseReg)
    else $error("literal arithmetic destination differs from base");

  chk_cond_branch: assert property (
    readyTake && (opc == cidt_pkg::OP_BRA_COND) && testTrue
      |=> !fetchReady ##1 fetchReady && decoded.squash)
    else $error("taken conditional branch not two cycles");

  chk_return_three: assert property (
    readyTake && ((opc == cidt_pkg::OP_RETURN) || (opc == cidt_pkg::OP_RET_INT))
      |=> !fetchReady [*2] ##1 fetchReady)
    else $error("return not three cycles");

  chk_branch_two: assert property (
    readyTake && (opc == cidt_pkg::OP_BRA_ALWAYS)
      |=> !fetchReady ##1 fetchReady)
    else $error("branch_always not two cycles");

  chk_skip_single: assert property (
    readyTake && cidt_pkg::isSkip(opc) && testTrue
      ##1 take && !cidt_pkg::isDoubleWord(opc)
      |=> decoded.squash && !decoded.execute && (s.phase == cidt_pkg::ST_READY))
    else $error("skip over single word not two cycles");

  chk_skip_double: assert property (
    readyTake && cidt_pkg::isSkip(opc) && testTrue
      ##1 take && cidt_pkg::isDoubleWord(opc) ##1 take
      |=> decoded.squash && !decoded.execute && (s.phase == cidt_pkg::ST_READY))
    else $error("skip over double word not three cycles");

  chk_dword_two: assert property (
    readyTake && cidt_pkg::isDoubleWord(opc) ##1 take
      |=> decoded.execute && decoded.doubleWord && (decoded.cycles == cidt_pkg::CYC_TWO))
    else $error("double-word form not finished in two cycles");

  chk_squash_quiet: assert property (
    decoded.squash |-> !decoded.execute)
    else $error("squashed cycle has side effects");

  chk_word_regs: assert property (
    readyTake && (opcCat == cidt_pkg::CAT_WORDBYTE) && !opc[cidt_pkg::FORM_BIT]
      |=> (decoded.ops.baseReg == $past(wBase))
          && (decoded.ops.sourceReg == $past(wSrc))
          && (decoded.ops.destReg == $past(wDest))
          && !decoded.ops.useFile)
    else $error("register operands not taken from word");

  chk_word_modes: assert property (
    readyTake && (opcCat == cidt_pkg::CAT_WORDBYTE) && !opc[cidt_pkg::FORM_BIT]
      |=> (decoded.ops.destMode == $past(opc[cidt_pkg::DMODE_HI:cidt_pkg::DMODE_LO]))
          && (decoded.ops.sourceMode
              == $past(fetch.word[cidt_pkg::SMODE_HI:cidt_pkg::SMODE_LO])))
    else $error("address modifiers not taken from word");

  chk_file_operand: assert property (
    readyTake && (opcCat == cidt_pkg::CAT_WORDBYTE) && opc[cidt_pkg::FORM_BIT]
      |=> decoded.ops.useFile
          && (decoded.ops.fileAddr == $past(fetch.word[cidt_pkg::FILE_HI:cidt_pkg::FILE_LO]))
          && (decoded.ops.toWorkingRegZero == $past(fetch.word[cidt_pkg::WZ_BIT])))
    else $error("file operand or destination select lost");

  chk_bit_position: assert property (
    readyTake && (opcCat == cidt_pkg::CAT_BIT)
      |=> decoded.ops.bitPos == $past(fetch.word[cidt_pkg::BPOS_HI:cidt_pkg::BPOS_LO]))
    else $error("bit position not taken from word");

  chk_bit_indirect: assert property (
    readyTake && (opcCat == cidt_pkg::CAT_BIT) && !opc[cidt_pkg::VAR_BIT]
      |=> (decoded.ops.bitIndirect == $past(fetch.word[cidt_pkg::BIND_BIT]))
          && (decoded.ops.baseReg == $past(wDest))
          && (decoded.ops.sourceReg == $past(wSrc)))
    else $error("indirect bit operands lost");

  chk_bit_file: assert property (
    readyTake && (opcCat == cidt_pkg::CAT_BIT) && opc[cidt_pkg::VAR_BIT]
      |=> decoded.ops.useFile && !decoded.ops.bitIndirect
          && (decoded.ops.fileAddr[cidt_pkg::BFILE_HI:cidt_pkg::FILE_LO]
              == $past(fetch.word[cidt_pkg::BFILE_HI:cidt_pkg::FILE_LO])))
    else $error("bit file operand lost");

  chk_lit_move: assert property (
    readyTake && (opcCat == cidt_pkg::CAT_LITERAL) && (opc != cidt_pkg::OP_MOVLIT_DW)
      && !opc[cidt_pkg::FORM_BIT] && !opc[cidt_pkg::VAR_BIT]
      |=> (decoded.ops.baseReg == $past(wSrc))
          && (decoded.ops.literal == cidt_pkg::cidt_literal_type'(
                $past(fetch.word[cidt_pkg::LMOV_HI:cidt_pkg::LMOV_LO]))))
    else $error("literal move operands lost");

  chk_lit_file: assert property (
    readyTake && (opcCat == cidt_pkg::CAT_LITERAL)
      && !opc[cidt_pkg::FORM_BIT] && opc[cidt_pkg::VAR_BIT]
      |=> decoded.ops.useFile
          && (decoded.ops.fileAddr == cidt_pkg::cidt_faddr_type'(
                $past(fetch.word[cidt_pkg::LFA_HI:cidt_pkg::FILE_LO]))))
    else $error("literal file target lost");

  chk_lit_arith: assert property (
    readyTake && (opcCat == cidt_pkg::CAT_LITERAL) && opc[cidt_pkg::FORM_BIT]
      |=> (decoded.ops.baseReg == $past(wBase))
          && (decoded.ops.destReg == $past(opc[cidt_pkg::VAR_BIT] ? wSrc : wBase)))
    else $error("literal arithmetic operands lost");

  chk_wide_literal: assert property (
    readyTake && (opc == cidt_pkg::OP_MOVLIT_DW) ##1 take
      |=> decoded.ops.useFile && decoded.doubleWord
          && (decoded.ops.literal == $past(fetch.word[cidt_pkg::PADR_HI:cidt_pkg::PADR_LO])))
    else $error("second word literal lost");

  chk_prog_addr: assert property (
    readyTake && ((opc == cidt_pkg::OP_GOTO_DW) || (opc == cidt_pkg::OP_CALL_DW)) ##1 take
      |=> decoded.ops.progAddr == {$past(fetch.word[cidt_pkg::PEXT_HI:cidt_pkg::FILE_LO]),
                                   $past(fetch.word[cidt_pkg::PADR_HI:cidt_pkg::PADR_LO], 2)})
    else $error("program address not joined from both words");

  chk_table_mode: assert property (
    readyTake && ((opc == cidt_pkg::OP_TBL_READ) || (opc == cidt_pkg::OP_TBL_WRITE))
      |=> decoded.ops.tableMode == $past(fetch.word[cidt_pkg::TMOD_HI:cidt_pkg::TMOD_LO]))
    else $error("table mode not taken from word");

  chk_table_two: assert property (
    readyTake && ((opc == cidt_pkg::OP_TBL_READ) || (opc == cidt_pkg::OP_TBL_WRITE)
                  || (opc == cidt_pkg::OP_CALL_IND) || (opc == cidt_pkg::OP_GOTO_IND))
      |=> (decoded.cycles == cidt_pkg::CYC_TWO) && !fetchReady ##1 fetchReady)
    else $error("table access or indirect jump not two cycles");

  chk_move_double: assert property (
    readyTake && (opc == cidt_pkg::OP_MOVE_DBL)
      |=> (decoded.cycles == cidt_pkg::CYC_TWO) && !fetchReady ##1 fetchReady)
    else $error("double move not two cycles");

  chk_plain_single: assert property (
    readyTake && (opcCat != cidt_pkg::CAT_CONTROL) && (opc != cidt_pkg::OP_MOVE_DBL)
      && !cidt_pkg::isDoubleWord(opc) && !(cidt_pkg::isSkip(opc) && testTrue)
      |=> fetchReady && (decoded.cycles == cidt_pkg::CYC_ONE))
    else $error("plain instruction not one cycle");

  chk_cond_fall: assert property (
    readyTake && (opc == cidt_pkg::OP_BRA_COND) && !testTrue
      |=> fetchReady && (decoded.cycles == cidt_pkg::CYC_ONE))
    else $error("untaken conditional branch not one cycle");

  chk_stall_squash: assert property (
    !fetchReady |=> decoded.squash && !decoded.execute)
    else $error("stall cycle not a nop");

  chk_skip_wait: assert property (
    (s.phase == cidt_pkg::ST_SKIP) && !take |=> !decoded.squash && !decoded.execute)
    else $error("skip squash without a fetched word");

  chk_skip_false: assert property (
    readyTake && cidt_pkg::isSkip(opc) && !testTrue
      |=> decoded.execute && (decoded.cycles == cidt_pkg::CYC_ONE)
          && (s.phase == cidt_pkg::ST_READY))
    else $error("untaken skip not one cycle");

endmodule : cidt_decoder
`default_nettype wire

// [bench/cidt_fetch_model.sv]
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// program memory fetch path: offers queued words, holds each until taken
module cidt_fetch_model (
  input  wire logic                     clock,
  input  wire logic                     nrst,
  input  wire logic                     fetchReady,
  input  wire logic                     slow,
  output var  cidt_pkg::cidt_fetch_type fetch,
  output var  logic                     testTrue
);
  cidt_pkg::cidt_word_type words[$];
  logic                    trues[$];
  logic                    take;
  logic                    gap;

  task automatic push(input cidt_pkg::cidt_word_type w, input logic t);
    words.push_back(w);
    trues.push_back(t);
  endtask : push

  initial begin
    fetch = '0;
    testTrue = 1'b0;
    take = 1'b0;
    gap = 1'b0;
  end

  always @(posedge clock) begin
    take = nrst && fetch.valid && fetchReady;
  end

  // released lines show the inverse of the last value
  always @(negedge clock) begin
    if (take) begin
      void'(words.pop_front());
      void'(trues.pop_front());
    end
    gap = take && slow;
    if (nrst && words.size() > 0 && !gap) begin
      fetch.valid = 1'b1;
      fetch.word = words[0];
      testTrue = trues[0];
    end else begin
      fetch.valid = 1'b0;
      fetch.word = ~fetch.word;
      testTrue = ~testTrue;
    end
  end
endmodule : cidt_fetch_model
`default_nettype wire

// [bench/tb_cpu_instruction_decode_timing.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_cpu_instruction_decode_timing;
  logic                      clock;
  logic                      nrst;
  logic                      slow;
  logic                      testTrue;
  logic                      fetchReady;
  cidt_pkg::cidt_fetch_type  fetch;
  cidt_pkg::cidt_decode_type decoded;
  int                        n_mismatch;
  int                        checks;
  int                        seed;
  int                        expSquash;
  int                        gotSquash;
  logic [23:0]               rw1[$];
  logic [23:0]               rw2[$];
  logic [1:0]                rcyc[$];
  logic [23:0]               mw1;
  logic [23:0]               mw2;
  logic [7:0]                opTab[17] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
    8'h07, 8'h08, 8'h09, 8'h0a, 8'h7c, 8'h7e, 8'h0a, 8'hbe, 8'h02, 8'hc2};

  cidt_decoder cidt_decoder_inst (.clock(clock), .nrst(nrst), .fetch(fetch),
    .testTrue(testTrue), .fetchReady(fetchReady), .decoded(decoded));
  cidt_fetch_model cidt_fetch_model_inst (.clock(clock), .nrst(nrst), .fetchReady(fetchReady),
    .slow(slow), .fetch(fetch), .testTrue(testTrue));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic dwOp(input logic [7:0] op);
    return op == 8'h09 || op == 8'h0a || op == 8'hc2;
  endfunction : dwOp

  task automatic check(input logic [95:0] seen, input logic [95:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done

  // builds a program and the expected execute stream and nop count
  task automatic gen(input int n);
    logic [7:0]  op;
    logic [23:0] w1;
    logic [23:0] w2;
    logic        t;
    logic        skipNext;
    int          extra;
    skipNext = 1'b0;
    for (int i = 0; i < n || skipNext; i++) begin
      op = (i < 17) ? opTab[i] : (i >= n) ? 8'h00 : 8'($random(seed));
      if (i >= 17 && i < n && $random(seed) % 2 == 0)
        op = opTab[unsigned'($random(seed)) % 17];
      w1 = {op, 16'($random(seed))};
      w2 = {8'h00, 16'($random(seed))};
      t = (i < 17) ? 1'b1 : 1'($random(seed));
      cidt_fetch_model_inst.push(w1, t);
      if (dwOp(op))
        cidt_fetch_model_inst.push(w2, t);
      if (skipNext) begin
        expSquash += dwOp(op) ? 2 : 1;
        skipNext = 1'b0;
      end else begin
        case (op)
          8'h01, 8'h03, 8'h04, 8'h05, 8'h06, 8'h7c: extra = 1;
          8'h07, 8'h08: extra = 2;
          8'h02: extra = t;
          default: extra = 0;
        endcase
        skipNext = (op == 8'h7e || op == 8'hbe) && t;
        expSquash += extra;
        rw1.push_back(w1);
        rw2.push_back(w2);
        rcyc.push_back(dwOp(op) ? 2'h2 : 2'(1 + extra));
      end
    end
  endtask : gen

  task automatic drain;
    for (int k = 0; k < 5000 && (cidt_fetch_model_inst.words.size() > 0 || rw1.size() > 0); k++)
      @(negedge clock);
    repeat (4) @(negedge clock);
    check(rw1.size(), 0);
    check(gotSquash, expSquash);
  endtask : drain

  ////////////////////////////////////////////////////////////////////////////////
  // compares every decoded instruction with the expected stream
  always @(negedge clock) begin
    if (nrst && decoded.squash)
      gotSquash++;
    if (nrst && decoded.execute) begin
      check(decoded.squash, 1'b0);
      check(rw1.size() != 0, 1'b1);
      mw1 = rw1.pop_front();
      mw2 = rw2.pop_front();
      check(decoded.opcode, mw1[23:16]);
      check(decoded.category, mw1[23:22]);
      check(decoded.cycles, rcyc.pop_front());
      check(decoded.doubleWord, dwOp(mw1[23:16]));
      if (mw1[23:16] == 8'hc2)
        check(decoded.ops.literal, mw2[15:0]);
      else if (dwOp(mw1[23:16]))
        check(decoded.ops.progAddr, {mw2[6:0], mw1[15:0]});
      else if (mw1[23:22] == 2'b01 && mw1[21])
        check({decoded.ops.toWorkingRegZero, decoded.ops.fileAddr}, mw1[14:0]);
      else if (mw1[23:22] == 2'b01)
        check({decoded.ops.baseReg, decoded.ops.destReg, decoded.ops.sourceReg},
          {mw1[14:11], mw1[10:7], mw1[3:0]});
      else if (mw1[23:22] == 2'b10)
        check(decoded.ops.bitPos, mw1[15:12]);
      else if (mw1[23:22] == 2'b11 && mw1[21])
        check(decoded.ops.baseReg, mw1[14:11]);
      else if (mw1[23:22] == 2'b11 && !mw1[16])
        check(decoded.ops.baseReg, mw1[3:0]);
      else if (mw1[23:22] == 2'b11)
        check({decoded.ops.literal, decoded.ops.fileAddr},
          {8'h00, mw1[15:8], 6'h00, mw1[7:0]});
      else
        check({decoded.ops.progAddr, decoded.ops.tableMode},
          {7'h00, mw1[15:0], mw1[15:14]});
    end
  end

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  initial begin
    #100000;
    n_mismatch++;
    test_done();
  end

  initial begin
    seed = 6;
    nrst = 1'b0;
    slow = 1'b0;
    n_mismatch = 0;
    checks = 0;
    expSquash = 0;
    gotSquash = 0;
    repeat (3) @(negedge clock);
    check(decoded, '0);
    check(fetchReady, 1'b1);
    nrst = 1'b1;
    gen(150);
    drain();
    slow = 1'b1;
    gen(150);
    drain();
    nrst = 1'b0;
    @(negedge clock);
    check(decoded, '0);
    check(fetchReady, 1'b1);
    nrst = 1'b1;
    slow = 1'b0;
    gen(20);
    drain();
    test_done();
  end
endmodule : tb_cpu_instruction_decode_timing
`default_nettype wire
